// [logic/gp_timer_consts.vh]
// Behaviour
// - Finest prescaled count step is two system clocks.
// - Each timer: prescaled clock or external input.
// - Direction from software or external direction pin.
// - Toggle latch flips on core overflow/underflow.
// - Latch clocks aux timer and drives pin.
// - Core overflow pulses feed second compare unit.
// - Core overflow can reload from capture register.
// - Capture pin edge latches aux timer value.
// - Optional clear of aux timer after capture.
// - Neighbour count/direction edges may trigger capture.
// - Aux timer has no external direction pin.
`ifndef GP_TIMER_CONSTS_VH
`define GP_TIMER_CONSTS_VH

// ****************************************************************
// Timer constants
// ****************************************************************
`define TMR_WIDTH        16
`define TMR_RESET_VAL    16'h0000
`define PRE_WIDTH        3
`define BASE_STEP        2
`define SRC_PRESCALE     2'h0
`define SRC_EXT_EDGE     2'h1
`define SRC_LATCH_EDGE   2'h2
`define SRC_STOP         2'h3
`define CAP_SEL_PIN      2'h0
`define CAP_SEL_NCOUNT   2'h1
`define CAP_SEL_NDIR     2'h2
`define CAP_SEL_NBOTH    2'h3

`endif

// [logic/gp_timer_counter.v]
`timescale 1ns/10ps
`include "gp_timer_consts.vh"

module gp_timer_counter #(
    parameter WIDTH = `TMR_WIDTH
) (
    // Clock and reset
    input  wire             sys_clk_i,
    input  wire             reset_i,
    // Control
    input  wire             step_i,
    input  wire             count_down_i,
    input  wire             load_i,
    input  wire [WIDTH-1:0] load_val_i,
    // Status
    output reg  [WIDTH-1:0] count_o,
    output wire             wrap_o
);

    // Wrap is combinational so the owner can react in the same cycle.
    assign wrap_o = step_i & (count_down_i ? (count_o == {WIDTH{1'b0}}) : (count_o == {WIDTH{1'b1}}));

    // A load takes priority over a count step in the same cycle.
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_o <= {WIDTH{1'b0}};
        end else if (load_i) begin
            count_o <= load_val_i;
        end else if (step_i) begin
            count_o <= count_down_i ? count_o - 1'b1 : count_o + 1'b1;
        end
    end

endmodule // gp_timer_counter

// [logic/gp_timer_capture_reload.v]
`timescale 1ns/10ps
`include "gp_timer_consts.vh"

module gp_timer_capture_reload #(
    parameter WIDTH = `TMR_WIDTH,
    parameter PRE_W = `PRE_WIDTH
) (
    // Clock and reset
    input  wire             sys_clk_i,
    input  wire             reset_i,
    // Aux timer configuration
    input  wire             aux_run_i,
    input  wire [1:0]       aux_src_i,
    input  wire [PRE_W-1:0] aux_prescale_i,
    input  wire             aux_dir_down_i,
    input  wire             aux_ext_count_i,
    // Core timer configuration
    input  wire             core_run_i,
    input  wire [1:0]       core_src_i,
    input  wire [PRE_W-1:0] core_prescale_i,
    input  wire             core_dir_down_i,
    input  wire             core_dir_ext_en_i,
    input  wire             direction_control_input_i,
    input  wire             core_ext_count_i,
    input  wire             core_reload_en_i,
    input  wire             latch_out_en_i,
    // Capture configuration and pins
    input  wire             capture_en_i,
    input  wire [1:0]       capture_sel_i,
    input  wire             capture_clear_en_i,
    input  wire             capture_input_pin_i,
    input  wire             neighbour_count_input_i,
    input  wire             neighbour_direction_input_i,
    // Outputs
    output wire [WIDTH-1:0] aux_timer_o,
    output wire [WIDTH-1:0] core_timer_o,
    output reg  [WIDTH-1:0] capture_reload_reg_o,
    output reg              core_toggle_latch_o,
    output reg              toggle_latch_output_pin_o,
    output reg              second_compare_unit_clk_o,
    output reg              capture_event_o
);

    // ****************************************************************
    // Edge detection and base tick
    // ****************************************************************
    reg             base_ff;
    reg [15:0]      pre_cnt_ff;
    reg             aux_ext_ff;
    reg             core_ext_ff;
    reg             cap_pin_ff;
    reg             n_cnt_ff;
    reg             n_dir_ff;
    reg             latch_seen_ff;
    wire            aux_wrap;
    wire            core_wrap;

    // Any transition on a level seen against its previous sample.
    function edge_of;
        input now_v;
        input last_v;
        begin
            edge_of = now_v ^ last_v;
        end
    endfunction

    // Prescale tick: base step of two clocks times 2^prescale.
    function tick_of;
        input [15:0]      cnt_v;
        input [PRE_W-1:0] sel_v;
        input             base_v;
        reg   [15:0]      mask_v;
        begin
            mask_v  = (16'h0001 << sel_v) - 16'h0001;
            tick_of = base_v & ((cnt_v & mask_v) == 16'h0000);
        end
    endfunction

    // Base toggles every clock, so the fastest tick comes every two clocks.
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            base_ff       <= 1'b0;
            pre_cnt_ff    <= 16'h0000;
        end else begin
            base_ff <= ~base_ff;
            if (base_ff) begin
                pre_cnt_ff <= pre_cnt_ff + 16'h0001;
            end
        end
    end

    // Previous samples of every input that is watched for edges.
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            aux_ext_ff    <= 1'b0;
            core_ext_ff   <= 1'b0;
            cap_pin_ff    <= 1'b0;
            n_cnt_ff      <= 1'b0;
            n_dir_ff      <= 1'b0;
            latch_seen_ff <= 1'b0;
        end else begin
            aux_ext_ff    <= aux_ext_count_i;
            core_ext_ff   <= core_ext_count_i;
            cap_pin_ff    <= capture_input_pin_i;
            n_cnt_ff      <= neighbour_count_input_i;
            n_dir_ff      <= neighbour_direction_input_i;
            latch_seen_ff <= core_toggle_latch_o;
        end
    end

    // ****************************************************************
    // Step selection
    // ****************************************************************
    reg  aux_step;
    reg  core_step;
    wire aux_pre_tick  = tick_of(pre_cnt_ff, aux_prescale_i, base_ff);
    wire core_pre_tick = tick_of(pre_cnt_ff, core_prescale_i, base_ff);
    // The aux timer has no direction pin; software alone steers it.
    wire aux_down      = aux_dir_down_i;
    wire core_down     = core_dir_ext_en_i ? direction_control_input_i : core_dir_down_i;

    // Pick each timer's count source.
    always @* begin
        aux_step  = 1'b0;
        core_step = 1'b0;
        case (aux_src_i)
            `SRC_PRESCALE:   aux_step = aux_pre_tick;
            `SRC_EXT_EDGE:   aux_step = edge_of(aux_ext_count_i, aux_ext_ff);
            `SRC_LATCH_EDGE: aux_step = edge_of(core_toggle_latch_o, latch_seen_ff);
            default:         aux_step = 1'b0;
        endcase
        case (core_src_i)
            `SRC_PRESCALE:   core_step = core_pre_tick;
            `SRC_EXT_EDGE:   core_step = edge_of(core_ext_count_i, core_ext_ff);
            default:         core_step = 1'b0;
        endcase
        aux_step  = aux_step & aux_run_i;
        core_step = core_step & core_run_i;
    end

    // ****************************************************************
    // Capture trigger
    // ****************************************************************
    reg cap_trig;

    // Capture on pin edges or neighbour input edges.
    always @* begin
        case (capture_sel_i)
            `CAP_SEL_PIN:    cap_trig = edge_of(capture_input_pin_i, cap_pin_ff);
            `CAP_SEL_NCOUNT: cap_trig = edge_of(neighbour_count_input_i, n_cnt_ff);
            `CAP_SEL_NDIR:   cap_trig = edge_of(neighbour_direction_input_i, n_dir_ff);
            default:         cap_trig = edge_of(neighbour_count_input_i, n_cnt_ff) |
                                        edge_of(neighbour_direction_input_i, n_dir_ff);
        endcase
        cap_trig = cap_trig & capture_en_i;
    end

    wire core_reload = core_wrap & core_reload_en_i;

    // ****************************************************************
    // Timers
    // ****************************************************************
    gp_timer_counter #(
        .WIDTH (WIDTH)
    ) u_aux_timer (
        .sys_clk_i    (sys_clk_i),
        .reset_i      (reset_i),
        .step_i       (aux_step),
        .count_down_i (aux_down),
        .load_i       (cap_trig & capture_clear_en_i),
        .load_val_i   ({WIDTH{1'b0}}),
        .count_o      (aux_timer_o),
        .wrap_o       (aux_wrap)
    );

    // Reload uses the register value present in the wrap cycle.
    gp_timer_counter #(
        .WIDTH (WIDTH)
    ) u_core_timer (
        .sys_clk_i    (sys_clk_i),
        .reset_i      (reset_i),
        .step_i       (core_step),
        .count_down_i (core_down),
        .load_i       (core_reload),
        .load_val_i   (capture_reload_reg_o),
        .count_o      (core_timer_o),
        .wrap_o       (core_wrap)
    );

    // ****************************************************************
    // Capture register, latch and event outputs
    // ****************************************************************
    // Capture takes the aux value before any clear in the same edge.
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            capture_reload_reg_o      <= `TMR_RESET_VAL;
            core_toggle_latch_o       <= 1'b0;
            toggle_latch_output_pin_o <= 1'b0;
            second_compare_unit_clk_o <= 1'b0;
            capture_event_o           <= 1'b0;
        end else begin
            if (cap_trig) begin
                capture_reload_reg_o <= aux_timer_o;
            end
            if (core_wrap) begin
                core_toggle_latch_o <= ~core_toggle_latch_o;
            end
            toggle_latch_output_pin_o <= latch_out_en_i & (core_toggle_latch_o ^ core_wrap);
            second_compare_unit_clk_o <= core_wrap;
            capture_event_o           <= cap_trig;
        end
    end

endmodule // gp_timer_capture_reload

// [verif/gp_timer_chk.sv]
`timescale 1ns/10ps
// ******************************
// Port checker for the timer block.
// ******************************
module gp_timer_chk (
    // Clock and reset
    input wire        sys_clk_i,
    input wire        reset_i,
    // Configuration
    input wire        aux_dir_down_i,
    input wire        core_dir_down_i,
    input wire        core_dir_ext_en_i,
    input wire        direction_control_input_i,
    input wire        core_reload_en_i,
    input wire        latch_out_en_i,
    input wire        capture_en_i,
    input wire        capture_clear_en_i,
    // Observed outputs
    input wire [15:0] aux_timer_o,
    input wire [15:0] core_timer_o,
    input wire [15:0] capture_reload_reg_o,
    input wire        core_toggle_latch_o,
    input wire        toggle_latch_output_pin_o,
    input wire        second_compare_unit_clk_o,
    input wire        capture_event_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // A capture pulse shows the value and the clear made at the edge before it.
    cap_load_a: assert property (
        capture_event_o |-> capture_reload_reg_o == $past(aux_timer_o)) else $error("capture value wrong");
    cap_clear_a: assert property (
        capture_event_o && $past(capture_clear_en_i) |-> aux_timer_o == '0) else $error("aux not cleared");
    cap_gate_a: assert property (
        !$past(capture_en_i) |-> !capture_event_o) else $error("capture while disabled");
    // Plain steps move by exactly one in the selected direction; wraps are judged apart.
    core_step_a: assert property (
        $changed(core_timer_o) && !$changed(core_toggle_latch_o) |-> 16'(core_timer_o - $past(core_timer_o))
        == ($past(core_dir_ext_en_i ? direction_control_input_i : core_dir_down_i) ? 16'hFFFF : 1))
        else $error("core step wrong");
    aux_step_a: assert property (
        $changed(aux_timer_o) && !capture_event_o |-> 16'(aux_timer_o - $past(aux_timer_o))
        == ($past(aux_dir_down_i) ? 16'hFFFF : 1)) else $error("aux step wrong");
    // The pin is the gated latch; every latch flip comes with a wrap pulse.
    latch_pin_a: assert property (
        toggle_latch_output_pin_o == (core_toggle_latch_o & $past(latch_out_en_i))) else $error("pin wrong");
    wrap_pulse_a: assert property (
        $changed(core_toggle_latch_o) |-> ##[0:1] second_compare_unit_clk_o) else $error("no wrap pulse");
    reload_a: assert property (
        $changed(core_toggle_latch_o) && $past(core_reload_en_i) |-> core_timer_o == $past(capture_reload_reg_o))
        else $error("reload value wrong");
endmodule // gp_timer_chk

// [verif/gp_pin_model.sv]
`timescale 1ns/10ps
// ******************************
// Far-side pin driver.
// ******************************
module gp_pin_model (
    input wire       sys_clk_i,
    output reg [5:0] pins_o
);
    initial pins_o = 6'h00;
    // Flip one pin after a falling edge and hold it two clocks, so no two edges merge.
    task automatic flip(input int n);
        @(negedge sys_clk_i);
        pins_o[n] = ~pins_o[n];
        repeat (2) @(negedge sys_clk_i);
    endtask
endmodule // gp_pin_model

// [verif/tb_top.sv]
`timescale 1ns/10ps
// ******************************
// Timer block bench.
// ******************************
module tb_top;
    reg sys_clk_i = 1'b0;
    reg reset_i = 1'b1;
    reg aux_run_i, aux_dir_down_i, core_run_i, core_dir_down_i, core_dir_ext_en_i;
    reg core_reload_en_i, latch_out_en_i, capture_en_i, capture_clear_en_i;
    reg [1:0] aux_src_i, core_src_i, capture_sel_i;
    reg [2:0] aux_prescale_i, core_prescale_i;
    wire [15:0] aux_timer_o, core_timer_o, capture_reload_reg_o;
    wire core_toggle_latch_o, toggle_latch_output_pin_o, second_compare_unit_clk_o, capture_event_o;
    wire [5:0] pin;
    int miscompares = 0, n_tests = 0, n_wrap = 0, n_cap = 0;
    // Clock, pin model and block.
    always #2 sys_clk_i = ~sys_clk_i;
    gp_pin_model u_pm (.sys_clk_i(sys_clk_i), .pins_o(pin));
    gp_timer_capture_reload u_dut (.*, .capture_input_pin_i(pin[0]), .neighbour_count_input_i(pin[1]),
        .neighbour_direction_input_i(pin[2]), .core_ext_count_i(pin[3]), .aux_ext_count_i(pin[4]),
        .direction_control_input_i(pin[5]));
    // Pulses stand one cycle only, so they are counted at every edge.
    always @(posedge sys_clk_i) begin
        n_wrap += second_compare_unit_clk_o;
        n_cap += capture_event_o;
    end
    task chk(string nm, logic [15:0] e, logic [15:0] s);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("FAIL %s exp %h got %h", nm, e, s);
        end
    endtask
    task end_sim;
        if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task cyc(int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task rst;
        reset_i = 1'b1;
        cyc(4);
        reset_i = 1'b0;
    endtask
    // Aux counts pin edges; each capture source in turn grabs and clears it.
    task t_cap;
        aux_run_i = 1'b1;
        aux_src_i = 2'h1;
        capture_en_i = 1'b1;
        capture_clear_en_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            capture_sel_i = i[1:0];
            aux_dir_down_i = i[0];
            repeat (3) u_pm.flip(4);
            u_pm.flip(i == 0 ? 0 : (i == 2 ? 2 : 1));
            chk("capture", i[0] ? 16'hFFFD : 16'h0003, capture_reload_reg_o);
            chk("clear", 16'h0000, aux_timer_o);
        end
        capture_sel_i = 2'h0;
        capture_en_i = 1'b0;
        u_pm.flip(0);
        chk("refused", 16'h0004, n_cap[15:0]);
    endtask
    // Core wraps down from zero with reload, then up past the top without it.
    task t_rel;
        core_run_i = 1'b1;
        core_src_i = 2'h1;
        core_dir_down_i = 1'b1;
        core_reload_en_i = 1'b1;
        latch_out_en_i = 1'b1;
        u_pm.flip(3);
        chk("reload", 16'hFFFD, core_timer_o);
        chk("latch", 16'h0001, {15'h0000, toggle_latch_output_pin_o});
        aux_src_i = 2'h2;
        core_reload_en_i = 1'b0;
        core_dir_down_i = 1'b0;
        repeat (3) u_pm.flip(3);
        chk("plain wrap", 16'h0000, core_timer_o);
        chk("latch back", 16'h0000, {15'h0000, core_toggle_latch_o});
        chk("latch clock", 16'hFFFF, aux_timer_o);
        chk("wraps", 16'h0002, n_wrap[15:0]);
    endtask
    // Rate and direction over a fixed window; a stopped timer holds.
    task t_rate;
        logic [15:0] a;
        core_src_i = 2'h0;
        for (int i = 0; i < 3; i++) begin
            if (i == 2)
                u_pm.flip(5);
            core_prescale_i = i[2:0] & 3'h1;
            core_dir_down_i = (i == 1);
            core_dir_ext_en_i = (i == 2);
            a = core_timer_o;
            cyc(20);
            chk("rate", i == 0 ? 16'h000A : (i == 1 ? 16'hFFFB : 16'hFFF6), core_timer_o - a);
        end
        core_run_i = 1'b0;
        a = core_timer_o;
        cyc(8);
        chk("stopped", a, core_timer_o);
        // The stop source code must hold the count even while run is high.
        core_run_i = 1'b1;
        core_src_i = 2'h3;
        a = core_timer_o;
        cyc(8);
        chk("stop source", a, core_timer_o);
    endtask
    initial begin
        {aux_run_i, aux_dir_down_i, core_run_i, core_dir_down_i, core_dir_ext_en_i, core_reload_en_i} = 6'h00;
        {latch_out_en_i, capture_en_i, capture_clear_en_i, aux_src_i, core_src_i, capture_sel_i} = 9'h000;
        {aux_prescale_i, core_prescale_i} = 6'h00;
        rst();
        t_cap();
        t_rel();
        rst();
        t_rate();
        end_sim();
    end
    // A hang is cut short and counted.
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
endmodule // tb_top
bind gp_timer_capture_reload gp_timer_chk u_chk (.*);
